/* inc/cbu_pkg.sv */
package cbu_pkg;
   // instruction layout: 24-bit word, top byte is the opcode
   localparam int INSTR_W      = 24;
   localparam int PC_W         = 23;
   localparam int OPC_HI       = 23;
   localparam int OPC_LO       = 16;
   localparam int OFS_W        = 16;
   // opcode bytes of the branch group
   localparam logic [7:0] OPC_CARRY_CLEAR = 8'h39;
   localparam logic [7:0] OPC_MINUS       = 8'h33;
   localparam logic [7:0] OPC_NOT_MINUS   = 8'h3B;
   localparam logic [7:0] OPC_NO_OVERFLOW = 8'h38;
   // status_word flag positions
   localparam int SW_CARRY     = 0;
   localparam int SW_ZERO      = 1;
   localparam int SW_RANGE     = 2;
   localparam int SW_MINUS     = 3;
   localparam int SW_W         = 16;
   // no-operation word placed in the instruction register
   localparam logic [23:0] NOP_WORD = 24'h000000;
   // program counter step per instruction word
   localparam logic [22:0] PC_STEP  = 23'h000002;
   localparam logic [22:0] PC_RESET = 23'h000000;
   // taken-branch cycle totals for the two core variants
   localparam int TAKEN_CYC_BASE = 2;
   localparam int TAKEN_CYC_ENH  = 4;
   localparam int STALL_W        = 2;

   typedef enum logic [1:0] {
      CBU_COND_NONE,
      CBU_COND_CARRY_CLEAR,
      CBU_COND_MINUS,
      CBU_COND_NOT_MINUS
   } cbu_dummy_t;
endpackage

/* core/cbu_cond.sv */
`timescale 1ns/1ps
// opcode match and condition evaluation, purely combinational
module cbu_cond
(
   // instruction and flags
   input  wire logic [23:0] instr_i,
   input  wire logic [15:0] status_i,
   // decode results
   output logic             is_branch_o,
   output logic             cond_true_o
);
   logic [7:0] opc;
   logic       carry;
   logic       minus;
   logic       range;

   assign opc   = instr_i[cbu_pkg::OPC_HI:cbu_pkg::OPC_LO];
   assign carry = status_i[cbu_pkg::SW_CARRY];
   assign minus = status_i[cbu_pkg::SW_MINUS];
   assign range = status_i[cbu_pkg::SW_RANGE];

   always_comb
   begin
      is_branch_o = 1'b1;
      cond_true_o = 1'b0;
      unique case (opc)
         // below-unsigned and carry-clear share this byte
         cbu_pkg::OPC_CARRY_CLEAR: cond_true_o = ~carry;   // [RL1] [RL2] [RL3]
         cbu_pkg::OPC_MINUS:       cond_true_o = minus;    // [RL4]
         cbu_pkg::OPC_NOT_MINUS:   cond_true_o = ~minus;   // [RL5]
         cbu_pkg::OPC_NO_OVERFLOW: cond_true_o = ~range;   // [RL6]
         default:                  is_branch_o = 1'b0;
      endcase
   end
endmodule

/* core/cbu_top.sv */
// Functional notes
// RL1 - below-unsigned taken only when carry clear
// RL2 - carry-clear opcode 0x39, taken when carry zero
// RL3 - below-unsigned and carry-clear share one encoding
// RL4 - minus opcode 0x33, taken when minus set
// RL5 - not-minus opcode 0x3B, taken when minus clear
// RL6 - no-overflow opcode 0x38, taken when range clear
// RL7 - taken: pc = (pc+2)+2*offset, flags untouched
// RL8 - low sixteen bits: signed instruction count
// RL9 - offset spans -32768 to +32767
// RL10 - taken branch puts NOP into instruction register
// RL11 - base core: 1 cycle, 2 if taken
// RL12 - enhanced core: 1 cycle, 4 if taken
// RL13 - not taken: pc steps to next word only
`timescale 1ns/1ps
module cbu_top
#(
   parameter bit ENHANCED = 1'b0
)
(
   // clock and reset
   input  wire logic        CLK_I,
   input  wire logic        RESETN_I,
   // fetched instruction
   input  wire logic        INSTR_VALID_I,
   input  wire logic [23:0] INSTR_I,
   // processor flags
   input  wire logic [15:0] STATUS_I,
   // program counter and instruction register
   output logic      [22:0] PC_O,
   output logic      [23:0] IR_O,
   output logic             IR_VALID_O,
   // branch status
   output logic             BUSY_O,
   output logic             TAKEN_O,
   output logic             NOT_BRANCH_O
);
   localparam logic [1:0] STALL_CYC = ENHANCED ?
      2'(cbu_pkg::TAKEN_CYC_ENH - 1) : 2'(cbu_pkg::TAKEN_CYC_BASE - 1);

   logic        is_branch;
   logic        cond_true;
   logic        accept;
   logic        take;
   logic [1:0]  stall_cnt;
   logic signed [15:0] ofs;
   logic [22:0] next_pc;
   logic [22:0] seq_pc;

   cbu_cond u_cond
   (
      .instr_i     (INSTR_I),
      .status_i    (STATUS_I),
      .is_branch_o (is_branch),
      .cond_true_o (cond_true)
   );

   // new fetches are ignored while the pipeline holds the inserted nops
   assign accept = INSTR_VALID_I && (stall_cnt == 2'h0);
   assign take   = accept && is_branch && cond_true;
   // offset counts instruction words, so it is doubled into bytes
   assign ofs    = $signed(INSTR_I[cbu_pkg::OFS_W-1:0]);                // [RL8] [RL9]
   assign seq_pc = PC_O + cbu_pkg::PC_STEP;

   always_comb
   begin
      next_pc = PC_O;
      if (take)
         next_pc = seq_pc + 23'(ofs <<< 1);                            // [RL7]
      else if (accept)
         next_pc = seq_pc;                                             // [RL13]
   end

   // program counter; status_word is only read, never written
   always_ff @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
         PC_O <= cbu_pkg::PC_RESET;
      else
         PC_O <= next_pc;                                              // [RL7]
   end

   // instruction register: a taken branch is followed by nops
   always_ff @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         IR_O       <= cbu_pkg::NOP_WORD;
         IR_VALID_O <= 1'b0;
      end
      else if (take || stall_cnt != 2'h0)
      begin
         IR_O       <= cbu_pkg::NOP_WORD;                              // [RL10]
         IR_VALID_O <= 1'b1;
      end
      else
      begin
         IR_O       <= INSTR_I;
         IR_VALID_O <= accept;
      end
   end

   // extra cycles after a taken branch
   always_ff @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
         stall_cnt <= 2'h0;
      else if (take)
         stall_cnt <= STALL_CYC;                                       // [RL11] [RL12]
      else if (stall_cnt != 2'h0)
         stall_cnt <= stall_cnt - 2'h1;
   end

   always_ff @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         BUSY_O       <= 1'b0;
         TAKEN_O      <= 1'b0;
         NOT_BRANCH_O <= 1'b0;
      end
      else
      begin
         BUSY_O       <= take || (stall_cnt > 2'h1);
         TAKEN_O      <= take;
         NOT_BRANCH_O <= accept && !is_branch;
      end
   end
endmodule

/* tb/cbu_chk.sv */
`timescale 1ns/1ps
module cbu_chk #(parameter bit ENHANCED = 1'b0)
(
   input logic        CLK_I, RESETN_I, INSTR_VALID_I,
   input logic [23:0] INSTR_I, IR_O,
   input logic [15:0] STATUS_I,
   input logic [22:0] PC_O,
   input logic        IR_VALID_O, BUSY_O, TAKEN_O, NOT_BRANCH_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RESETN_I);
   logic [7:0] op;
   logic       acc, br, hit;
   assign op = INSTR_I[23:16];
   assign acc = INSTR_VALID_I && !BUSY_O;
   assign br = op inside {8'h39, 8'h33, 8'h3B, 8'h38};
   assign hit = acc && (op == 8'h39 && !STATUS_I[0] || op == 8'h33 && STATUS_I[3]
      || op == 8'h3B && !STATUS_I[3] || op == 8'h38 && !STATUS_I[2]);
   // enhanced core holds three nop slots, base core one
   sequence nop_slots; BUSY_O [*3] ##1 !BUSY_O; endsequence
   sequence one_slot; BUSY_O ##1 !BUSY_O; endsequence
   AST_TGT: assert property (hit |=> PC_O == $past(PC_O) + 23'h000002
      + {{6{$past(INSTR_I[15])}}, $past(INSTR_I[15:0]), 1'b0}) else $error("target");
   AST_NOP: assert property (hit |=> TAKEN_O && IR_VALID_O && !IR_O)
      else $error("nop");
   AST_SKIP: assert property (acc && br && !hit |=> !TAKEN_O
      && IR_O == $past(INSTR_I)) else $error("skip");
   AST_STEP: assert property (acc && !hit |=> PC_O == $past(PC_O) + 23'h000002)
      else $error("step");
   AST_OTHER: assert property (acc && !br |=> NOT_BRANCH_O) else $error("other");
   AST_ENH: assert property (ENHANCED && hit |=> nop_slots) else $error("slots");
   AST_BASE: assert property (!ENHANCED && hit |=> one_slot) else $error("base");
   AST_HOLD: assert property (BUSY_O |=> $stable(PC_O) && !TAKEN_O) else $error("hold");
endmodule
bind cbu_top cbu_chk #(.ENHANCED(ENHANCED)) i_cbu_chk (.CLK_I, .RESETN_I, .INSTR_VALID_I,
   .INSTR_I, .IR_O, .STATUS_I, .PC_O, .IR_VALID_O, .BUSY_O, .TAKEN_O, .NOT_BRANCH_O);

/* tb/cbu_top_test.sv */
`timescale 1ns/1ps
module cbu_top_test;
   logic        clk = 1'b0, rst_n = 1'b0, vld = 1'b0, irv, bsy, tk, nb;
   logic [23:0] ins = 24'h000000, ir_o;
   logic [15:0] sts = 16'h0000;
   logic [22:0] pc = 23'h000000, pc_o;
   int          mismatches = 0, n_checks = 0;
   always #5 clk = ~clk;
   cbu_top #(.ENHANCED(1'b1)) i_cbu_top (.CLK_I(clk), .RESETN_I(rst_n), .INSTR_VALID_I(vld),
      .INSTR_I(ins), .STATUS_I(sts), .PC_O(pc_o), .IR_O(ir_o), .IR_VALID_O(irv), .BUSY_O(bsy),
      .TAKEN_O(tk), .NOT_BRANCH_O(nb));
   task automatic chk(input logic [23:0] got, exp);
      n_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: %h %h", $time, got, exp);
      end
   endtask
   // a taken word stays presented, so the nop slots must refuse it
   task automatic step(input logic [23:0] w, input logic [15:0] s, input logic t);
      pc = pc + 23'h000002 + (t ? {{6{w[15]}}, w[15:0], 1'b0} : 23'h000000);
      vld = 1'b1;
      ins = w;
      sts = s;
      @(negedge clk);
      chk(pc_o, pc);
      chk(tk, t);
      chk(ir_o, t ? 24'h000000 : w);
      chk(bsy, t);
      chk(irv, 1'b1);
      if (t)
         repeat (cbu_pkg::TAKEN_CYC_ENH - 1)
         begin
            @(negedge clk);
            chk(pc_o, pc);
            chk(ir_o, 24'h000000);
         end
   endtask
   task automatic t_cond;
      step(24'h390003, 16'h000E, 1'b1);
      step(24'h390003, 16'h0001, 1'b0);
      step(24'h33FFFE, 16'h0008, 1'b1);
      step(24'h33FFFE, 16'h0007, 1'b0);
      step(24'h3B7FFF, 16'h0007, 1'b1);
      step(24'h3B0010, 16'h0008, 1'b0);
      step(24'h388000, 16'h000B, 1'b1);
      step(24'h380005, 16'h0004, 1'b0);
   endtask
   task automatic t_other;
      step(24'h550004, 16'h0000, 1'b0);
      chk(nb, 1'b1);
   endtask
   task automatic wrap_up(input int late);
      mismatches += late;
      if (mismatches == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial #2000 wrap_up(1);
   initial
   begin
      repeat (3) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      t_cond();
      t_other();
      wrap_up(0);
   end
endmodule
